// ### mcr_pkg.sv
// shared constants of the metering configuration register bank
// assumes a word-addressed register port with printed offsets as addresses
`default_nettype none
package mcr_pkg;
    // ************************************************
    // register port
    // ************************************************
    localparam int              ADDR_W        = 12;
    localparam int              DATA_W        = 32;
    localparam logic [11:0]     OFS_CROSSBAR  = 12'h0424;
    localparam logic [11:0]     OFS_PULSE_CFG = 12'h0425;
    localparam logic [11:0]     OFS_PART_IDENTITY   = 12'h0472;
    localparam logic [11:0]     OFS_TRIM      = 12'h0474;
    localparam logic [11:0]     OFS_GENERAL_CONFIG_ONE   = 12'h0481;

    // ************************************************
    // channel source crossbar
    // ************************************************
    localparam int              CH_NUM        = 7;
    localparam int              SEL_W         = 3;
    localparam int              XBAR_W        = 21;
    localparam int              SAMPLE_W      = 24;
    localparam logic [2:0]      SEL_OWN       = 3'h7;
    localparam logic [20:0]     XBAR_RESET    = 21'h1F_FFFF;

    // ************************************************
    // pulse width configuration
    // ************************************************
    localparam int              PULSE_NUM     = 4;
    localparam int              LONG_EN_LSB   = 19;
    localparam int              WIDTH_W       = 19;
    localparam int              PCFG_W        = 23;
    localparam logic [22:0]     PCFG_RESET    = 23'h00_0000;

    // ************************************************
    // identity, trim, config one
    // ************************************************
    localparam int              PART_IDENTITY_POS   = 20;
    localparam int              TRIM_OFS_LSB  = 16;
    localparam logic [31:0]     TRIM_RESET    = 32'h0000_0000;
    localparam int              EXTERNAL_REFERENCE_SELECT_POS   = 15;
    localparam logic            EXTERNAL_REFERENCE_SELECT_RESET = 1'b0;

    // ************************************************
    // timing
    // ************************************************
    localparam int              CLK_PERIOD_NS   = 10;
    localparam int              TICK_NS         = 1000;
    localparam int              TICK_CYCLES     = TICK_NS / CLK_PERIOD_NS;
    localparam int              PULSE_FIXED_MS  = 80;
    localparam int              PULSE_FIXED_TICKS = PULSE_FIXED_MS * 1000000 / TICK_NS;
    localparam int              FREQ_LIMIT_MHZ  = 6250;
    localparam longint          PERIOD_LIMIT_TICKS = 64'd1000000000000 / FREQ_LIMIT_MHZ / TICK_NS;
    localparam int              CNT_W           = 18;

    typedef enum logic [0:0] {
        MCR_ST_IDLE   = 1'b0,
        MCR_ST_ACTIVE = 1'b1
    } mcr_pulse_state_t;
endpackage
`default_nettype wire

// ### mcr_pulse_shaper.sv
// active-low width shaper for one energy pulse output
// assumes fire is a one-cycle request and tick a one-cycle timebase enable
`default_nettype none
module mcr_pulse_shaper
    import mcr_pkg::*;
#(
    parameter logic [17:0] FIXED_TICKS = 18'(PULSE_FIXED_TICKS),
    parameter logic [17:0] LIMIT_TICKS = 18'(PERIOD_LIMIT_TICKS)
) (
    input  wire logic               mclk,
    input  wire logic               srst,
    input  wire logic               tick,
    input  wire logic               fire,
    input  wire logic               long_en,
    input  wire logic [WIDTH_W-1:0] long_width,
    output logic                    pulse_n
);
    mcr_pulse_state_t   state_r,     state_nxt;
    logic [WIDTH_W-1:0] remaining_r, remaining_nxt;
    logic [CNT_W-1:0]   period_r,    period_nxt;
    logic               pulse_n_nxt;
    logic [WIDTH_W-1:0] width_sel;

    // ************************************************
    // width selection and countdown
    // ************************************************
    always_comb begin
        if (long_en) begin
            width_sel = long_width;
        end else if (period_r >= LIMIT_TICKS) begin
            width_sel = {1'b0, FIXED_TICKS};
        end else begin
            // faster pulses get half the last period so they never merge
            width_sel = {2'b00, period_r[CNT_W-1:1]};
        end
        period_nxt    = period_r;
        state_nxt     = state_r;
        remaining_nxt = remaining_r;
        if (fire) begin
            period_nxt = '0;
        end else if (tick && period_r < LIMIT_TICKS) begin
            period_nxt = period_r + 18'h0_0001;
        end
        if (fire) begin
            remaining_nxt = width_sel;
            state_nxt     = (width_sel != '0) ? MCR_ST_ACTIVE : MCR_ST_IDLE;
        end else if (state_r == MCR_ST_ACTIVE && tick) begin
            remaining_nxt = remaining_r - 19'h0_0001;
            if (remaining_r == 19'h0_0001) begin
                state_nxt = MCR_ST_IDLE;
            end
        end
        pulse_n_nxt = (state_nxt != MCR_ST_ACTIVE);
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_r     <= MCR_ST_IDLE;
            remaining_r <= '0;
            period_r    <= LIMIT_TICKS;
            pulse_n     <= 1'b1;
        end else begin
            state_r     <= state_nxt;
            remaining_r <= remaining_nxt;
            period_r    <= period_nxt;
            pulse_n     <= pulse_n_nxt;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    sequence s_last_tick;
        state_r == MCR_ST_ACTIVE && remaining_r == 19'h0_0001 && tick && !fire;
    endsequence

    a_fire_drives_low: assert property (@(posedge mclk) disable iff (srst)
        fire && width_sel != '0 |=> !pulse_n) else $error("pulse did not go low on fire");
    a_fixed_width_load: assert property (@(posedge mclk) disable iff (srst)
        fire && !long_en && period_r >= LIMIT_TICKS |=> remaining_r == {1'b0, FIXED_TICKS})
        else $error("fixed width not loaded");
    a_long_width_load: assert property (@(posedge mclk) disable iff (srst)
        fire && long_en |=> remaining_r == $past(long_width)) else $error("long width not loaded");
    a_release_end: assert property (@(posedge mclk) disable iff (srst)
        s_last_tick |=> pulse_n) else $error("pulse not released at end of width");
endmodule
`default_nettype wire

// ### mcr_top.sv
// metering configuration register bank: crossbar, pulse widths, id, trim, reference
// assumes word-addressed register port driven synchronously to mclk
`default_nettype none
// Summary of operation
// - each channel select is 3 bits, resets to 111, 111 means own converter
// - selects sit at fixed 3-bit fields from phase A current up to phase C voltage
// - select 000..110 routes that converter index into the channel
// - four long enable bits at 22..19 pick the shared programmable width
// - with long enable clear and slow pulses, output is low for 80 ms
// - a 19-bit width value resetting to zero sets the long pulse width
// - part identity register shows one read-only bit at position 20
// - writable trim word: offset in upper half, gain in lower half
module mcr_top
    import mcr_pkg::*;
#(
    parameter logic        PART_IDENTITY_VALUE = 1'b0, // arbitrary value
    parameter logic [17:0] FIXED_TICKS   = 18'(PULSE_FIXED_TICKS),
    parameter logic [17:0] LIMIT_TICKS   = 18'(PERIOD_LIMIT_TICKS)
) (
    input  wire logic                             mclk,
    input  wire logic                             srst,
    input  wire logic [ADDR_W-1:0]                reg_addr,
    input  wire logic                             reg_wr,
    input  wire logic                             reg_rd,
    input  wire logic [DATA_W-1:0]                reg_wdata,
    output logic      [DATA_W-1:0]                reg_rdata,
    output logic                                  reg_rvalid,
    input  wire logic [CH_NUM-1:0][SAMPLE_W-1:0]  adc_data,
    input  wire logic                             adc_valid,
    output logic      [CH_NUM-1:0][SAMPLE_W-1:0]  chan_data,
    output logic                                  chan_valid,
    input  wire logic [PULSE_NUM-1:0]             pulse_fire,
    output logic      [PULSE_NUM-1:0]             energy_pulse_out_n,
    output logic                                  external_reference_select,
    output logic      [15:0]                      temp_offset,
    output logic      [15:0]                      temp_gain
);
    logic [XBAR_W-1:0]  xbar_r,  xbar_nxt;
    logic [PCFG_W-1:0]  pcfg_r,  pcfg_nxt;
    logic [DATA_W-1:0]  trim_r,  trim_nxt;
    logic               extref_r, extref_nxt;
    logic [DATA_W-1:0]  rdata_nxt;
    logic [CH_NUM-1:0][SAMPLE_W-1:0] chan_nxt;
    logic [6:0]         tick_cnt_r, tick_cnt_nxt;
    logic               tick;

    function automatic logic [2:0] src_index(input logic [2:0] sel, input int ch);
        return (sel == SEL_OWN) ? 3'(ch) : sel;
    endfunction

    // ************************************************
    // register writes and reads
    // ************************************************
    always_comb begin
        xbar_nxt   = xbar_r;
        pcfg_nxt   = pcfg_r;
        trim_nxt   = trim_r;
        extref_nxt = extref_r;
        rdata_nxt  = '0;
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_CROSSBAR:  xbar_nxt   = reg_wdata[XBAR_W-1:0];
                OFS_PULSE_CFG: pcfg_nxt   = reg_wdata[PCFG_W-1:0];
                OFS_TRIM:      trim_nxt   = reg_wdata;
                // reference select, other config bits not held
                OFS_GENERAL_CONFIG_ONE:   extref_nxt = reg_wdata[EXTERNAL_REFERENCE_SELECT_POS];
                default:       ;
            endcase
        end
        if (reg_rd) begin
            // reserved bits and unmapped words read zero
            unique case (reg_addr)
                OFS_CROSSBAR:  rdata_nxt = {{(DATA_W-XBAR_W){1'b0}}, xbar_r};
                OFS_PULSE_CFG: rdata_nxt = {{(DATA_W-PCFG_W){1'b0}}, pcfg_r};
                OFS_PART_IDENTITY:   rdata_nxt = 32'(PART_IDENTITY_VALUE) << PART_IDENTITY_POS;
                OFS_TRIM:      rdata_nxt = trim_r;
                OFS_GENERAL_CONFIG_ONE:   rdata_nxt = 32'(extref_r) << EXTERNAL_REFERENCE_SELECT_POS;
                default:       rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            xbar_r     <= XBAR_RESET;
            pcfg_r     <= PCFG_RESET;
            trim_r     <= TRIM_RESET;
            extref_r   <= EXTERNAL_REFERENCE_SELECT_RESET;
            reg_rdata  <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            xbar_r     <= xbar_nxt;
            pcfg_r     <= pcfg_nxt;
            trim_r     <= trim_nxt;
            extref_r   <= extref_nxt;
            reg_rdata  <= rdata_nxt;
            reg_rvalid <= reg_rd;
        end
    end

    // ************************************************
    // channel crossbar
    // ************************************************
    // per-channel source mux
    for (genvar ch = 0; ch < CH_NUM; ch++) begin : g_xbar
        always_comb begin
            chan_nxt[ch] = adc_data[src_index(xbar_r[ch*SEL_W +: SEL_W], ch)];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            chan_data  <= '0;
            chan_valid <= 1'b0;
        end else begin
            chan_data  <= adc_valid ? chan_nxt : chan_data;
            chan_valid <= adc_valid;
        end
    end

    // ************************************************
    // microsecond timebase and pulse outputs
    // ************************************************
    always_comb begin
        tick         = (tick_cnt_r == 7'(TICK_CYCLES - 1));
        tick_cnt_nxt = tick ? 7'h00 : tick_cnt_r + 7'h01;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
        end
    end

    // one shaper per output with its own enable
    for (genvar p = 0; p < PULSE_NUM; p++) begin : g_pulse
        mcr_pulse_shaper #(
            .FIXED_TICKS (FIXED_TICKS),
            .LIMIT_TICKS (LIMIT_TICKS)
        ) u_shaper (
            .mclk       (mclk),
            .srst       (srst),
            .tick       (tick),
            .fire       (pulse_fire[p]),
            .long_en    (pcfg_r[LONG_EN_LSB + p]),
            .long_width (pcfg_r[WIDTH_W-1:0]),
            .pulse_n    (energy_pulse_out_n[p])
        );
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            external_reference_select <= EXTERNAL_REFERENCE_SELECT_RESET;
            temp_offset               <= '0;
            temp_gain                 <= '0;
        end else begin
            external_reference_select <= extref_nxt;
            temp_offset               <= trim_nxt[DATA_W-1:TRIM_OFS_LSB];
            temp_gain                 <= trim_nxt[TRIM_OFS_LSB-1:0];
        end
    end

    // ************************************************
    // checks
    // ************************************************
    sequence s_trim_wr_rd;
        reg_wr && reg_addr == OFS_TRIM ##1 reg_rd && !reg_wr && reg_addr == OFS_TRIM;
    endsequence

    a_own_source: assert property (@(posedge mclk) disable iff (srst)
        adc_valid && xbar_r[2:0] == SEL_OWN |=> chan_data[0] == $past(adc_data[0]))
        else $error("channel did not take own converter");
    a_routed_source: assert property (@(posedge mclk) disable iff (srst)
        adc_valid && xbar_r[20:18] == 3'h0 |=> chan_data[6] == $past(adc_data[0]))
        else $error("routed source not taken");
    a_crossbar_write: assert property (@(posedge mclk) disable iff (srst)
        reg_wr && reg_addr == OFS_CROSSBAR |=> xbar_r == $past(reg_wdata[XBAR_W-1:0]))
        else $error("crossbar write lost");
    a_reserved_zero: assert property (@(posedge mclk) disable iff (srst)
        reg_rd && reg_addr == OFS_PULSE_CFG |=> reg_rvalid && reg_rdata[31:23] == 9'h000)
        else $error("reserved bits not zero");
    a_part_identity_read: assert property (@(posedge mclk) disable iff (srst)
        reg_rd && reg_addr == OFS_PART_IDENTITY |=> reg_rdata == (32'(PART_IDENTITY_VALUE) << PART_IDENTITY_POS))
        else $error("identity read wrong");
    a_trim_readback: assert property (@(posedge mclk) disable iff (srst)
        s_trim_wr_rd |=> reg_rdata == $past(reg_wdata, 2) && temp_gain == reg_rdata[15:0])
        else $error("trim read back wrong");
    a_external_reference_select_out: assert property (@(posedge mclk) disable iff (srst)
        reg_wr && reg_addr == OFS_GENERAL_CONFIG_ONE |=> external_reference_select == $past(reg_wdata[EXTERNAL_REFERENCE_SELECT_POS]))
        else $error("reference select not updated");
    a_width_reset: assert property (@(posedge mclk)
        $fell(srst) |-> pcfg_r == PCFG_RESET && energy_pulse_out_n == 4'hF)
        else $error("pulse config not reset");
    a_reset_crossbar: assert property (@(posedge mclk)
        $fell(srst) |-> xbar_r == XBAR_RESET && external_reference_select == EXTERNAL_REFERENCE_SELECT_RESET)
        else $error("crossbar or reference not reset");
    a_width_cfg_write: assert property (@(posedge mclk) disable iff (srst)
        reg_wr && reg_addr == OFS_PULSE_CFG |=> pcfg_r == $past(reg_wdata[PCFG_W-1:0]))
        else $error("pulse config write lost");
    a_trim_outputs: assert property (@(posedge mclk) disable iff (srst)
        reg_wr && reg_addr == OFS_TRIM |=> {temp_offset, temp_gain} == $past(reg_wdata))
        else $error("trim outputs not updated");
    a_config_reserved: assert property (@(posedge mclk) disable iff (srst)
        reg_rd && reg_addr == OFS_GENERAL_CONFIG_ONE |=> reg_rdata[31:16] == 16'h0000 && reg_rdata[14:0] == 15'h0000)
        else $error("config one reserved bits not zero");
    a_read_valid: assert property (@(posedge mclk) disable iff (srst)
        reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_sample_valid: assert property (@(posedge mclk) disable iff (srst)
        adc_valid |=> chan_valid)
        else $error("sample strobe not passed on");
    a_sample_hold: assert property (@(posedge mclk) disable iff (srst)
        !adc_valid |=> $stable(chan_data))
        else $error("channel data changed without a sample");
endmodule
`default_nettype wire

// ### mcr_notes_end.sv
`default_nettype none
`default_nettype wire

// ### testbench.sv
// self-checking bench for the metering configuration register bank
// assumes mcr_pkg and mcr_top compiled first; inputs change on falling edges
`default_nettype none
module testbench
    import mcr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************
    // signals and design
    // ************************************************
    localparam logic TB_ID = 1'b0; // arbitrary value
    logic                            mclk;
    logic                            srst;
    logic [ADDR_W-1:0]               reg_addr;
    logic                            reg_wr;
    logic                            reg_rd;
    logic [DATA_W-1:0]               reg_wdata;
    logic [DATA_W-1:0]               reg_rdata;
    logic                            reg_rvalid;
    logic [CH_NUM-1:0][SAMPLE_W-1:0] adc_data;
    logic                            adc_valid;
    logic [CH_NUM-1:0][SAMPLE_W-1:0] chan_data;
    logic                            chan_valid;
    logic [PULSE_NUM-1:0]            pulse_fire;
    logic [PULSE_NUM-1:0]            energy_pulse_out_n;
    logic                            external_reference_select;
    logic [15:0]                     temp_offset;
    logic [15:0]                     temp_gain;
    int                              num_errors = 0;
    int                              checked    = 0;
    int                              cyc        = 0;
    // short counts keep the 80 ms fixed pulse affordable
    mcr_top #(.PART_IDENTITY_VALUE(TB_ID), .FIXED_TICKS(18'h0_0008), .LIMIT_TICKS(18'h0_0010)) i_dut (
        .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .adc_data(adc_data), .adc_valid(adc_valid), .chan_data(chan_data), .chan_valid(chan_valid),
        .pulse_fire(pulse_fire), .energy_pulse_out_n(energy_pulse_out_n),
        .external_reference_select(external_reference_select),
        .temp_offset(temp_offset), .temp_gain(temp_gain));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    // ************************************************
    // shared tasks
    // ************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge mclk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge mclk);
        reg_wr    = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(negedge mclk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge mclk);
        reg_rd   = 1'b0;
        chk({31'h0000_0000, reg_rvalid}, 32'h0000_0001);
        chk(reg_rdata, exp);
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_reset_values();
        rd(OFS_CROSSBAR, 32'h001F_FFFF);
        rd(OFS_PULSE_CFG, 32'h0000_0000);
        rd(OFS_TRIM, 32'h0000_0000);
        rd(OFS_GENERAL_CONFIG_ONE, 32'h0000_0000);
        chk({28'h000_0000, energy_pulse_out_n}, 32'h0000_000F);
    endtask
    task automatic t_crossbar();
        logic [31:0] w;
        logic [2:0]  s;
        for (int k = 0; k < 8; k++) begin
            w = 32'hFFE0_0000;
            for (int ch = 0; ch < CH_NUM; ch++) begin
                w[3*ch +: 3] = 3'((ch + k) % 8);
                adc_data[ch] = SAMPLE_W'(32'h00A0_0000 + ch * 32'h0001_0111 + k);
            end
            wr(OFS_CROSSBAR, w);
            rd(OFS_CROSSBAR, {11'h000, w[20:0]});
            @(negedge mclk);
            adc_valid = 1'b1;
            @(negedge mclk);
            adc_valid = 1'b0;
            chk({31'h0000_0000, chan_valid}, 32'h0000_0001);
            for (int ch = 0; ch < CH_NUM; ch++) begin
                s = w[3*ch +: 3];
                // own converter when all ones
                chk({8'h00, chan_data[ch]}, {8'h00, adc_data[(s == SEL_OWN) ? ch : int'(s)]});
            end
        end
    endtask
    task automatic t_pulse(input int p, input int lo, input int hi);
        int n;
        n = 0;
        @(negedge mclk);
        pulse_fire[p] = 1'b1;
        @(negedge mclk);
        pulse_fire[p] = 1'b0;
        while (energy_pulse_out_n[p] === 1'b0 && n < 2000) begin
            n++;
            @(negedge mclk);
        end
        checked++;
        if (n < lo || n > hi) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, n, lo);
        end
    endtask
    task automatic t_pulses();
        wr(OFS_PULSE_CFG, 32'hFFFF_FFFF);
        rd(OFS_PULSE_CFG, 32'h007F_FFFF);
        wr(OFS_PULSE_CFG, 32'h0008_0003);
        t_pulse(0, 201, 300);
        // never fired since reset, so counted as slow
        t_pulse(1, 701, 800);
        wr(OFS_PULSE_CFG, 32'h0020_0000);
        t_pulse(2, 0, 0);
        // top enable bit belongs to the fourth output
        wr(OFS_PULSE_CFG, 32'h0040_0002);
        t_pulse(3, 101, 200);
    endtask
    task automatic t_trim_id_ref();
        @(negedge mclk);
        reg_addr  = OFS_TRIM;
        reg_wdata = 32'h1234_ABCD;
        reg_wr    = 1'b1;
        @(negedge mclk);
        // read right behind the write must see the new word
        reg_wr    = 1'b0;
        reg_rd    = 1'b1;
        chk({temp_offset, temp_gain}, 32'h1234_ABCD);
        @(negedge mclk);
        reg_rd    = 1'b0;
        chk({31'h0000_0000, reg_rvalid}, 32'h0000_0001);
        chk(reg_rdata, 32'h1234_ABCD);
        wr(OFS_PART_IDENTITY, 32'hFFFF_FFFF);
        rd(OFS_PART_IDENTITY, 32'(TB_ID) << PART_IDENTITY_POS);
        wr(OFS_GENERAL_CONFIG_ONE, 32'hFFFF_FFFF);
        chk({31'h0000_0000, external_reference_select}, 32'h0000_0001);
        rd(OFS_GENERAL_CONFIG_ONE, 32'h0000_8000);
        wr(OFS_GENERAL_CONFIG_ONE, 32'h0000_7FFF);
        chk({31'h0000_0000, external_reference_select}, 32'h0000_0000);
        rd(12'h0_400, 32'h0000_0000);
    endtask
    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        srst       = 1'b1;
        reg_addr   = 12'h0_000;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        reg_wdata  = 32'h0000_0000;
        adc_data   = '0;
        adc_valid  = 1'b0;
        pulse_fire = 4'h0;
        repeat (2) @(negedge mclk);
        srst = 1'b0;
        t_reset_values();
        t_crossbar();
        t_pulses();
        t_trim_id_ref();
        end_of_test();
    end
endmodule
`default_nettype wire
